// >>> rtl/owt_pkg.sv
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
package owt_pkg;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned CNT_W = 12;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL = 16'hF020;
  localparam logic [15:0] IDX_DIV_CUR = 16'hF021;
  localparam logic [15:0] IDX_WRAP = 16'hF022;
  localparam logic [15:0] IDX_COUNT = 16'hF023;
  localparam logic [15:0] IDX_STATUS = 16'hF024;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CNT_EN = 0;
  localparam int unsigned BIT_TRIG_EN = 1;
  localparam int unsigned BIT_TRIP = 0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic CNT_EN_RST = 1'h0;
  localparam logic TRIG_EN_RST = 1'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] WRAP_RST = 16'hFFFF;
  localparam logic [11:0] COUNT_RST = 12'hFFF;

  // ----------------------------------------------------------------
  // bus answers and register selection
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_DIV_CUR,
    SEL_WRAP,
    SEL_COUNT,
    SEL_STATUS,
    SEL_NONE
  } owt_sel_t;

endpackage

// >>> rtl/owt_prescaler.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// oscillator prescaler
// ----------------------------------------------------------------
module owt_prescaler
  import owt_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic resetn,
  // oscillator edge and wrap value
  input wire logic osc_edge,
  input wire logic [W-1:0] wrap,
  // divider state
  output logic [W-1:0] cur,
  output logic wrapped
);

  typedef struct packed {
    logic [W-1:0] cur;
  } owt_div_state_t;

  owt_div_state_t st;
  owt_div_state_t next_st;

  // wrap pulse fires in the same step that returns the count to zero
  assign wrapped = osc_edge && (st.cur == wrap);
  assign cur = st.cur;

  // advance only on oscillator edges, never on the system clock rate
  always_comb begin
    next_st = st;
    if (osc_edge) begin
      if (st.cur == wrap) begin
        next_st.cur = '0;
      end else begin
        next_st.cur = W'(st.cur + 1'b1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!resetn) begin
      st.cur <= W'(DIV_RST);
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!resetn);

  chk_only_osc: assert property (
    !osc_edge |=> $stable(st.cur))
    else $error("divider moved without an oscillator edge");
  chk_div_step: assert property (
    osc_edge && st.cur != wrap |=> st.cur == W'($past(st.cur) + 1'b1))
    else $error("divider did not advance by one");
  chk_div_wrap: assert property (
    osc_edge && st.cur == wrap |-> wrapped ##1 st.cur == '0)
    else $error("divider did not return to zero at wrap");

endmodule

// >>> rtl/owt_watchdog.sv
`timescale 1ns/10ps
// Notes on behaviour
// - After reset both counting and chip reset are off, so it idles.
// - Control bit 1, with bit 0 also set, allows expiry to reset the chip.
// - Control bit 0 enables the timeout counter; clear, it holds.
// - Counting with chip reset off is a count-only debug mode.
// - The 16-bit divider steps per oscillator edge and reads back.
// - At the wrap value the divider goes to zero and ticks the counter.
// - The wrap value is writable, resets to FFFF, divides by wrap+1.
// - The 12-bit counter is writable, resets to FFF, one step a period.
// - Counter at zero with counting and chip reset on asserts the chip reset.
// - The trip flag sets on a trip and only power-on reset clears it.
// - The divider runs from the oscillator pin, not the PLL.
module owt_watchdog
  import owt_pkg::*;
(
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // oscillator pin
  input wire logic crystal_input_pin,
  // chip reset request
  output logic chip_reset,
  // write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic osc_q;
    logic cnt_en;
    logic trig_en;
    logic [DIV_W-1:0] wrap;
    logic [CNT_W-1:0] count;
    logic chip_rst;
    logic tripped;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } owt_state_t;

  localparam owt_state_t ST_RESET = '{
    cnt_en: CNT_EN_RST,
    trig_en: TRIG_EN_RST,
    wrap: WRAP_RST,
    count: COUNT_RST,
    default: '0
  };

  owt_state_t st;
  owt_state_t next_st;

  logic sys_rst_n;
  logic osc_edge;
  logic [DIV_W-1:0] div_cur;
  logic div_wrap;
  logic wr_do;
  owt_sel_t wr_sel;
  owt_sel_t rd_sel;
  logic wr_count;
  logic [DATA_W-1:0] wr_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // map a byte address to a register, misaligned goes nowhere
  function automatic owt_sel_t decode(input logic [ADDR_W-1:0] a);
    owt_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[ADDR_W-1:2])
        IDX_CTRL: s = SEL_CTRL;
        IDX_DIV_CUR: s = SEL_DIV_CUR;
        IDX_WRAP: s = SEL_WRAP;
        IDX_COUNT: s = SEL_COUNT;
        IDX_STATUS: s = SEL_STATUS;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // word seen by software; reserved bits read as zero
  function automatic logic [DATA_W-1:0] reg_word(
    input owt_sel_t s,
    input owt_state_t q,
    input logic [DIV_W-1:0] cur
  );
    logic [DATA_W-1:0] w;
    w = '0;
    case (s)
      SEL_CTRL: begin
        w[BIT_CNT_EN] = q.cnt_en;
        w[BIT_TRIG_EN] = q.trig_en;
      end
      SEL_DIV_CUR: w[DIV_W-1:0] = cur;
      SEL_WRAP: w[DIV_W-1:0] = q.wrap;
      SEL_COUNT: w[CNT_W-1:0] = q.count;
      SEL_STATUS: w[BIT_TRIP] = q.tripped;
      default: w = '0;
    endcase
    return w;
  endfunction

  // byte-lane merge of a partial write into the present word
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] d,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // oscillator timebase
  // ----------------------------------------------------------------

  // the pin is synchronous, so one flop is enough for edge detection
  assign osc_edge = crystal_input_pin && !st.osc_q;

  // divider shares the watchdog reset; power-on also clears it
  assign sys_rst_n = aresetn && por_n;

  owt_prescaler #(
    .W(DIV_W)
  ) u_div (
    .aclk(aclk),
    .resetn(sys_rst_n),
    .osc_edge(osc_edge),
    .wrap(st.wrap),
    .cur(div_cur),
    .wrapped(div_wrap)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // a write commits once both address and data are held
  assign wr_do = st.aw_got && st.w_got;
  assign wr_sel = decode(st.aw_addr);
  assign rd_sel = decode(araddr);
  assign wr_count = wr_do && (wr_sel == SEL_COUNT);
  assign wr_word = merge(reg_word(wr_sel, st, div_cur), st.w_data,
                         st.w_strb);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.osc_q = crystal_input_pin;

    // decrement once per wrap, stop at zero instead of rolling over
    if (st.cnt_en && div_wrap && (st.count != '0)) begin
      next_st.count = CNT_W'(st.count - 1'b1);
    end

    // expiry only resets the chip while the trigger is armed
    if (st.cnt_en && st.trig_en && (st.count == '0)) begin
      next_st.chip_rst = 1'b1;
      next_st.tripped = 1'b1;
    end

    // address and data are caught separately, in either order
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end

    // commit; a counter rewrite beats a decrement in the same cycle
    if (wr_do) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wr_sel)
        SEL_CTRL: begin
          next_st.cnt_en = wr_word[BIT_CNT_EN];
          next_st.trig_en = wr_word[BIT_TRIG_EN];
        end
        SEL_WRAP: next_st.wrap = wr_word[DIV_W-1:0];
        SEL_COUNT: next_st.count = wr_word[CNT_W-1:0];
        default: next_st.bvalid = 1'b1;
      endcase
    end

    // read data is captured at address acceptance
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_word(rd_sel, st, div_cur);
      next_st.rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // a watchdog reset leaves the trip flag, only power-on clears it
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st <= ST_RESET;
    end else if (!aresetn) begin
      st <= ST_RESET;
      st.tripped <= st.tripped;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // new requests wait until the previous answer is taken
  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  // held until the chip reset comes back in on aresetn
  assign chip_reset = st.chip_rst;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  sequence s_both_held;
    st.aw_got && st.w_got;
  endsequence

  sequence s_wr_answer;
    bvalid && !awready && !wready;
  endsequence

  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  chk_idle_after_rst: assert property (
    aresetn && !$past(aresetn) |->
      !st.cnt_en && !st.trig_en && !chip_reset)
    else $error("timer not idle after reset");

  chk_reset_values: assert property (
    aresetn && !$past(aresetn) |->
      st.wrap == WRAP_RST && st.count == COUNT_RST)
    else $error("wrap or count wrong after reset");

  chk_need_trigger: assert property (
    $rose(chip_reset) |-> $past(st.trig_en) && $past(st.count) == '0)
    else $error("chip reset without trigger enable");

  chk_hold_disabled: assert property (
    !st.cnt_en && !wr_count |=> $stable(st.count))
    else $error("counter moved while disabled");

  chk_count_only: assert property (
    st.cnt_en && !st.trig_en && !chip_reset ##1 !st.trig_en |->
      !chip_reset)
    else $error("count-only mode reset the chip");

  chk_div_read: assert property (
    s_rd_taken ##0 rd_sel == SEL_DIV_CUR |=>
      rvalid && rdata == {16'h0000, $past(div_cur)})
    else $error("divider read back wrong");

  chk_dec_on_wrap: assert property (
    st.cnt_en && div_wrap && st.count != '0 && !wr_count |=>
      st.count == CNT_W'($past(st.count) - 1'b1))
    else $error("counter did not step on wrap");

  chk_no_wrap_step: assert property (
    !div_wrap && !wr_count |=> $stable(st.count))
    else $error("counter moved between wraps");

  chk_trip_reset: assert property (
    st.cnt_en && st.trig_en && st.count == '0 |=>
      chip_reset && st.tripped)
    else $error("expiry did not reset the chip");

  chk_trip_sticky: assert property (
    @(posedge aclk) disable iff (!por_n)
    st.tripped |=> st.tripped)
    else $error("trip flag lost without power-on reset");

  chk_hold_zero: assert property (
    st.count == '0 && !wr_count |=> st.count == '0)
    else $error("counter left zero without a write");

  chk_wr_resp: assert property (
    s_both_held |=> s_wr_answer)
    else $error("write not answered one cycle after commit");

  chk_rd_stable: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped before taken");

endmodule

// >>> tb/tb_oscillator_watchdog_timer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bench for the oscillator watchdog
// ----------------------------------------------------------------
module tb_oscillator_watchdog_timer
  import owt_pkg::*;
;
  localparam logic [17:0] A_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [17:0] A_DIV = {IDX_DIV_CUR, 2'h0};
  localparam logic [17:0] A_WRAP = {IDX_WRAP, 2'h0};
  localparam logic [17:0] A_CNT = {IDX_COUNT, 2'h0};
  localparam logic [17:0] A_STAT = {IDX_STATUS, 2'h0};
  logic aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0, osc = 1'h0;
  logic chip_reset, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int comparisons = 0;

  // 4 ns clock
  always #2 aclk = ~aclk;

  owt_watchdog DUT (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .crystal_input_pin(osc), .chip_reset(chip_reset),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // ----------------------------------------------------------------
  // comparison and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master tasks
  // ----------------------------------------------------------------
  // address and data offered together, bready held until the answer
  // no local limit: only the bench watchdog ends a hung wait
  task automatic wr(input logic [17:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // read data and response are taken at the rvalid edge
  task automatic rd(input logic [17:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // rising oscillator edges, slow against aclk
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      osc <= 1'h1;
      @(posedge aclk);
      osc <= 1'h0;
    end
    repeat (2) @(posedge aclk);
  endtask

  // system reset, or power-on reset as well
  task automatic do_reset(input bit por);
    @(posedge aclk);
    aresetn <= 1'h0;
    if (por) por_n <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    por_n <= 1'h1;
  endtask

  // ----------------------------------------------------------------
  // watchdog against a hung bench
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b1);
    // values after power-on
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_DIV, 32'h0, RESP_OKAY);
    rd(A_WRAP, 32'h0000FFFF, RESP_OKAY);
    // byte strobes merge into the present value
    wstrb <= 4'h1;
    wr(A_WRAP, 32'h00000012, RESP_OKAY);
    wstrb <= 4'hF;
    rd(A_WRAP, 32'h0000FF12, RESP_OKAY);
    rd(A_CNT, 32'h00000FFF, RESP_OKAY);
    rd(A_STAT, 32'h0, RESP_OKAY);
    // holes in the map answer with an error
    rd(18'h3C0A0, 32'h0, RESP_SLVERR);
    rd(18'h3C081, 32'h0, RESP_SLVERR);
    wr(18'h3C0A0, 32'h1, RESP_SLVERR);
    // read-only divider ignores writes
    wr(A_DIV, 32'h1234, RESP_OKAY);
    rd(A_DIV, 32'h0, RESP_OKAY);
    // divider divides by wrap plus one, counter idle
    wr(A_WRAP, 32'h2, RESP_OKAY);
    pulse(2);
    rd(A_DIV, 32'h2, RESP_OKAY);
    pulse(1);
    rd(A_DIV, 32'h0, RESP_OKAY);
    rd(A_CNT, 32'h00000FFF, RESP_OKAY);
    check({31'h0, chip_reset}, 32'h0);
    // count-only mode runs down and holds at zero
    do_reset(1'b0);
    wr(A_WRAP, 32'h1, RESP_OKAY);
    wr(A_CNT, 32'h2, RESP_OKAY);
    wr(A_CTRL, 32'h1, RESP_OKAY);
    pulse(2);
    rd(A_CNT, 32'h1, RESP_OKAY);
    pulse(4);
    rd(A_CNT, 32'h0, RESP_OKAY);
    check({31'h0, chip_reset}, 32'h0);
    rd(A_STAT, 32'h0, RESP_OKAY);
    // serviced watchdog, then left to expire
    do_reset(1'b0);
    wr(A_WRAP, 32'h1, RESP_OKAY);
    wr(A_CNT, 32'h2, RESP_OKAY);
    wr(A_CTRL, 32'h3, RESP_OKAY);
    rd(A_CTRL, 32'h3, RESP_OKAY);
    pulse(3);
    rd(A_CNT, 32'h1, RESP_OKAY);
    wr(A_CNT, 32'h2, RESP_OKAY);
    pulse(2);
    rd(A_CNT, 32'h1, RESP_OKAY);
    check({31'h0, chip_reset}, 32'h0);
    pulse(1);
    rd(A_CNT, 32'h0, RESP_OKAY);
    pulse(2);
    check({31'h0, chip_reset}, 32'h1);
    rd(A_STAT, 32'h1, RESP_OKAY);
    // the trip flag survives a system reset, not a power-on reset
    do_reset(1'b0);
    @(posedge aclk);
    check({31'h0, chip_reset}, 32'h0);
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_STAT, 32'h1, RESP_OKAY);
    do_reset(1'b1);
    rd(A_STAT, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule
